/* core/smc_pkg.sv */
// constants and types for the standby and slow mode controller
`default_nettype none
package smc_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TB_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  // power_mode_control_reg fields
  localparam int HF_OSC_BIT     = 7;
  localparam int LF_OSC_BIT     = 6;
  localparam int MAIN_CLK_BIT   = 5;
  localparam int HALT_REQ_BIT   = 4;
  localparam int TG_STOP_BIT    = 2;
  localparam logic [7:0] POWER_CTRL_RST = 8'h80;
  localparam logic [7:0] POWER_CTRL_WMASK = 8'hf4;
  // time_base_control_reg fields
  localparam int TB_EN_BIT      = 3;
  localparam int TB_SEL_LSB     = 0;
  localparam int TB_SEL_W       = 3;
  localparam logic [7:0] TB_CTRL_RST = 8'h00;
  localparam logic [7:0] TB_CTRL_WMASK = 8'h0f;
  // widths
  localparam int NUM_IRQ        = 16;
  localparam int NUM_TB_SRC     = 8;
  localparam int PC_W           = 16;
  localparam logic [15:0] PC_HOLD_OFFSET = 16'h0002;
  // clock changeover synchronisation time
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SYNC_TIME_NS   = 400;
  localparam int SYNC_CYCLES    = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_LAST = 3'(SYNC_CYCLES - 1);

  typedef enum logic [2:0] {
    SMC_SINGLE_RUN    = 3'h0,
    SMC_DUAL_FAST_RUN = 3'h1,
    SMC_LOW_ONLY      = 3'h2,
    SMC_LOW_WITH_FAST = 3'h3,
    SMC_FAST_CPU_HALT = 3'h4,
    SMC_SLOW_CPU_HALT = 3'h5,
    SMC_FAST_DEEP     = 3'h6,
    SMC_SLOW_DEEP     = 3'h7
  } smc_mode_t;

  typedef enum logic [2:0] {
    SMC_ST_RUN      = 3'b001,
    SMC_ST_CPU_HALT = 3'b010,
    SMC_ST_DEEP     = 3'b100
  } smc_state_t;
endpackage
`default_nettype wire

/* core/smc_top.sv */
// standby and slow mode controller with wishbone register access
// Behaviour
// - cpu halt modes stop cpu and watchdog; peripherals keep running
// - all halt modes freeze memory, registers, status word and port latches
// - while halted the pc holds the start instruction address plus two
// - writing halt request 1 enters fast or slow cpu halt by run mode
// - leaving cpu halt clears the halt request and resumes previous run mode
// - reset pin low ends any mode; restart in single clock run mode
// - master enable 0: enabled source wakes, resume without interrupt service
// - master enable 1: enabled source wakes and starts its service
// - watchdog interrupt just before entry is serviced; halt not entered
// - deep halt stops peripheral clocks except the time base timer
// - writing timing stop request 1 enters fast or slow deep halt
// - leaving deep halt clears the stop request and resumes run mode
// - deep halt ignores time base enable; if set, time base latch sets
// - product zero: selected source falling edge wakes without service
// - product one: selected source falling edge wakes and starts service
// - deep halt release is asynchronous and may come early
// - main clock select 1 moves to low clock; then stop fast oscillator
// - fast oscillator on, warm up, then clear main clock select
// - after select clears, stay on low clock until clocks synchronise
`timescale 1ns/1ps
`default_nettype none
module smc_top (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // external reset pin
  input  wire logic                         reset_pin_n_i,
  // cpu and interrupt controller
  input  wire logic                         interrupt_master_enable_i,
  input  wire logic [smc_pkg::NUM_IRQ-1:0]  interrupt_enable_flags_i,
  input  wire logic [smc_pkg::NUM_IRQ-1:0]  interrupt_latches_i,
  input  wire logic                         time_base_irq_enable_i,
  input  wire logic                         watchdog_irq_i,
  input  wire logic [smc_pkg::PC_W-1:0]     halt_instr_addr_i,
  // time base source clocks, asynchronous
  input  wire logic [smc_pkg::NUM_TB_SRC-1:0] tb_src_clk_i,
  // halt control
  output logic                              cpu_halt_o,
  output logic                              watchdog_halt_o,
  output logic                              state_hold_o,
  output logic      [smc_pkg::PC_W-1:0]     halt_pc_o,
  output logic                              periph_clk_en_o,
  output logic                              tbt_clk_en_o,
  output logic                              wake_o,
  output logic                              irq_service_o,
  output logic                              tbt_latch_set_o,
  // clock control
  output logic                              hf_osc_en_o,
  output logic                              lf_osc_en_o,
  output logic                              sys_clk_low_o,
  output logic      [2:0]                   operating_mode_o
);
  import smc_pkg::*;

  smc_state_t                state;
  logic [7:0]                power_ctrl;
  logic [7:0]                tb_ctrl;
  logic                      pin_s1;
  logic                      pin_s2;
  logic [NUM_TB_SRC-1:0]     tb_s1;
  logic [NUM_TB_SRC-1:0]     tb_s2;
  logic [NUM_TB_SRC-1:0]     tb_s3;
  logic [2:0]                sync_cnt;
  logic                      core_rst;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      halt_req;
  logic                      stop_req;
  logic                      tb_fall;
  logic                      cpu_wake;
  logic                      deep_wake;
  logic                      enter_cpu;
  logic                      enter_deep;
  logic                      cancel_wdt;
  logic                      cancel_both;
  logic                      tb_service;

  function automatic logic [7:0] merge_byte(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] mask);
    merge_byte = (cur & ~mask) | (wd & mask);
  endfunction

  function automatic logic [2:0] mode_code(input smc_state_t st, input logic low,
                                           input logic hf, input logic lf);
    smc_mode_t m;
    m = SMC_SINGLE_RUN;
    unique case (st)
      SMC_ST_CPU_HALT: m = low ? SMC_SLOW_CPU_HALT : SMC_FAST_CPU_HALT;
      SMC_ST_DEEP:     m = low ? SMC_SLOW_DEEP : SMC_FAST_DEEP;
      SMC_ST_RUN: begin
        if (low) begin
          m = hf ? SMC_LOW_WITH_FAST : SMC_LOW_ONLY;
        end else begin
          m = lf ? SMC_DUAL_FAST_RUN : SMC_SINGLE_RUN;
        end
      end
    endcase
    mode_code = m;
  endfunction

  // reset pin passes two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= reset_pin_n_i;
      pin_s2 <= pin_s1;
    end
  end

  assign core_rst = rst_i | ~pin_s2;

  // source clocks are asynchronous; edge detect looks only at later stages
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      tb_s1 <= '0;
      tb_s2 <= '0;
      tb_s3 <= '0;
    end else begin
      tb_s1 <= tb_src_clk_i;
      tb_s2 <= tb_s1;
      tb_s3 <= tb_s2;
    end
  end

  assign halt_req    = power_ctrl[HALT_REQ_BIT];
  assign stop_req    = power_ctrl[TG_STOP_BIT];
  assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr      = bus_req & wb_we_i & wb_sel_i[0];
  // the release edge is not aligned to the selected period, so it can come early
  assign tb_fall     = tb_s3[tb_ctrl[TB_SEL_LSB +: TB_SEL_W]] &
                       ~tb_s2[tb_ctrl[TB_SEL_LSB +: TB_SEL_W]];
  assign cpu_wake    = (state == SMC_ST_CPU_HALT) &
                       (|(interrupt_enable_flags_i & interrupt_latches_i));
  assign deep_wake   = (state == SMC_ST_DEEP) & tb_fall;
  assign cancel_both = (state == SMC_ST_RUN) & halt_req & stop_req;
  assign cancel_wdt  = (state == SMC_ST_RUN) & (halt_req ^ stop_req) & watchdog_irq_i;
  assign enter_cpu   = (state == SMC_ST_RUN) & halt_req & ~stop_req & ~watchdog_irq_i;
  assign enter_deep  = (state == SMC_ST_RUN) & stop_req & ~halt_req & ~watchdog_irq_i;
  assign tb_service  = interrupt_master_enable_i & time_base_irq_enable_i & tb_ctrl[TB_EN_BIT];

  // control registers; hardware clears of the requests win over nothing else
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      power_ctrl <= POWER_CTRL_RST;
      tb_ctrl    <= TB_CTRL_RST;
    end else begin
      if (bus_wr && wb_adr_i == ADDR_POWER_CTRL) begin
        power_ctrl <= merge_byte(power_ctrl, wb_dat_i[7:0], POWER_CTRL_WMASK);
      end else if (cpu_wake || cancel_both || (cancel_wdt && halt_req)) begin
        power_ctrl[HALT_REQ_BIT] <= 1'b0;
        power_ctrl[TG_STOP_BIT]  <= power_ctrl[TG_STOP_BIT] & ~cancel_both;
      end else if (deep_wake || (cancel_wdt && stop_req)) begin
        power_ctrl[TG_STOP_BIT] <= 1'b0;
      end
      if (bus_wr && wb_adr_i == ADDR_TB_CTRL) begin
        tb_ctrl <= merge_byte(tb_ctrl, wb_dat_i[7:0], TB_CTRL_WMASK);
      end
    end
  end

  // halt state machine and its outputs
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      state           <= SMC_ST_RUN;
      cpu_halt_o      <= 1'b0;
      watchdog_halt_o <= 1'b0;
      state_hold_o    <= 1'b0;
      periph_clk_en_o <= 1'b1;
      tbt_clk_en_o    <= 1'b1;
      halt_pc_o       <= '0;
      wake_o          <= 1'b0;
      irq_service_o   <= 1'b0;
      tbt_latch_set_o <= 1'b0;
    end else begin
      wake_o          <= 1'b0;
      irq_service_o   <= 1'b0;
      tbt_latch_set_o <= 1'b0;
      unique case (state)
        SMC_ST_RUN: begin
          if (cancel_wdt) begin
            irq_service_o <= 1'b1;
          end else if (enter_cpu) begin
            state           <= SMC_ST_CPU_HALT;
            cpu_halt_o      <= 1'b1;
            watchdog_halt_o <= 1'b1;
            state_hold_o    <= 1'b1;
            halt_pc_o       <= halt_instr_addr_i + PC_HOLD_OFFSET;
          end else if (enter_deep) begin
            state           <= SMC_ST_DEEP;
            cpu_halt_o      <= 1'b1;
            watchdog_halt_o <= 1'b1;
            state_hold_o    <= 1'b1;
            periph_clk_en_o <= 1'b0;
            halt_pc_o       <= halt_instr_addr_i + PC_HOLD_OFFSET;
            tbt_latch_set_o <= tb_ctrl[TB_EN_BIT];
          end
        end
        SMC_ST_CPU_HALT: begin
          if (cpu_wake) begin
            state           <= SMC_ST_RUN;
            cpu_halt_o      <= 1'b0;
            watchdog_halt_o <= 1'b0;
            state_hold_o    <= 1'b0;
            wake_o          <= 1'b1;
            irq_service_o   <= interrupt_master_enable_i;
          end
        end
        SMC_ST_DEEP: begin
          if (deep_wake) begin
            state           <= SMC_ST_RUN;
            cpu_halt_o      <= 1'b0;
            watchdog_halt_o <= 1'b0;
            state_hold_o    <= 1'b0;
            periph_clk_en_o <= 1'b1;
            wake_o          <= 1'b1;
            irq_service_o   <= tb_service;
          end
        end
      endcase
    end
  end

  // system clock changeover; going fast waits for the clocks to line up
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      sys_clk_low_o <= 1'b0;
      sync_cnt      <= '0;
    end else if (power_ctrl[MAIN_CLK_BIT]) begin
      sys_clk_low_o <= 1'b1;
      sync_cnt      <= '0;
    end else if (sys_clk_low_o && power_ctrl[HF_OSC_BIT]) begin
      if (sync_cnt == SYNC_LAST) begin
        sys_clk_low_o <= 1'b0;
        sync_cnt      <= '0;
      end else begin
        sync_cnt <= sync_cnt + 3'h1;
      end
    end else begin
      sync_cnt <= '0;
    end
  end

  // fast oscillator stays under software control; warm up is timed outside
  assign hf_osc_en_o = power_ctrl[HF_OSC_BIT];
  assign lf_osc_en_o = power_ctrl[LF_OSC_BIT];

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      operating_mode_o <= SMC_SINGLE_RUN;
    end else begin
      operating_mode_o <= mode_code(state, sys_clk_low_o, power_ctrl[HF_OSC_BIT],
                                    power_ctrl[LF_OSC_BIT]);
    end
  end

  // bus answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        unique case (wb_adr_i)
          ADDR_POWER_CTRL: wb_dat_o <= {24'h0, power_ctrl};
          ADDR_TB_CTRL:    wb_dat_o <= {24'h0, tb_ctrl};
          ADDR_STATUS:     wb_dat_o <= {26'h0, sys_clk_low_o, state, operating_mode_o[1:0]};
          default:         wb_dat_o <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  halt_keeps_periph_a: assert property (
    (state == SMC_ST_CPU_HALT) |-> watchdog_halt_o && periph_clk_en_o && cpu_halt_o)
    else $error("cpu halt did not stop watchdog or stopped peripherals");

  halt_holds_state_a: assert property (
    (cpu_halt_o || !periph_clk_en_o) |-> state_hold_o)
    else $error("state not held during halt");

  halt_pc_value_a: assert property (
    $rose(cpu_halt_o) |-> halt_pc_o == $past(halt_instr_addr_i) + PC_HOLD_OFFSET)
    else $error("held pc is not start address plus two");

  cpu_halt_entry_a: assert property (
    enter_cpu && !core_rst |=> cpu_halt_o && periph_clk_en_o)
    else $error("halt request did not enter cpu halt");

  cpu_halt_exit_a: assert property (
    cpu_wake && !core_rst |=> !halt_req && !cpu_halt_o && wake_o)
    else $error("cpu halt exit did not clear request");

  pin_reset_mode_a: assert property (
    !pin_s2 |=> ##1 operating_mode_o == SMC_SINGLE_RUN && !cpu_halt_o)
    else $error("reset pin did not restore single clock run");

  wake_service_a: assert property (
    cpu_wake && !core_rst |=> irq_service_o == $past(interrupt_master_enable_i))
    else $error("wake service does not follow master enable");

  wdt_cancel_a: assert property (
    cancel_wdt && !core_rst |=> !cpu_halt_o && irq_service_o && !halt_req && !stop_req)
    else $error("watchdog interrupt did not cancel halt");

  deep_gating_a: assert property (
    (state == SMC_ST_DEEP) |-> !periph_clk_en_o && tbt_clk_en_o)
    else $error("deep halt clock gating wrong");

  tb_latch_set_a: assert property (
    enter_deep && !core_rst |=> tbt_latch_set_o == $past(tb_ctrl[TB_EN_BIT]))
    else $error("time base latch not set on deep entry");

  deep_wake_a: assert property (
    deep_wake && !core_rst |=> wake_o && !stop_req && periph_clk_en_o
    && irq_service_o == $past(tb_service))
    else $error("deep halt release wrong");

  clk_to_low_a: assert property (
    power_ctrl[MAIN_CLK_BIT] && !core_rst |=> sys_clk_low_o)
    else $error("system clock did not move to low clock");

  clk_sync_wait_a: assert property (
    $fell(power_ctrl[MAIN_CLK_BIT]) && power_ctrl[HF_OSC_BIT] && !core_rst
    && !$past(core_rst) |-> sys_clk_low_o [*4] ##1 !sys_clk_low_o)
    else $error("clock changed over before synchronisation");

  both_req_drop_a: assert property (
    cancel_both && !core_rst |=> !halt_req && !stop_req && !cpu_halt_o)
    else $error("double request not dropped");

  deep_halt_entry_a: assert property (
    enter_deep && !core_rst |=> cpu_halt_o && !periph_clk_en_o && stop_req)
    else $error("stop request did not enter deep halt");

  quiet_wake_a: assert property (
    cpu_wake && !interrupt_master_enable_i && !core_rst |=> wake_o && !irq_service_o)
    else $error("wake with master enable 0 started a service");

  deep_quiet_wake_a: assert property (
    deep_wake && !tb_service && !core_rst |=> wake_o && !irq_service_o && !cpu_halt_o)
    else $error("deep halt release without service started a service");

  deep_exit_clear_a: assert property (
    deep_wake && !core_rst |=> !stop_req && state == SMC_ST_RUN)
    else $error("deep halt exit did not clear stop request");

  slow_halt_mode_a: assert property (
    enter_cpu && power_ctrl[MAIN_CLK_BIT] && !core_rst
    |=> ##1 operating_mode_o == SMC_SLOW_CPU_HALT || $past(core_rst))
    else $error("halt from low clock did not report slow cpu halt");

  low_clk_hold_a: assert property (
    sys_clk_low_o && !power_ctrl[HF_OSC_BIT] && !core_rst |=> sys_clk_low_o)
    else $error("system clock left low clock with fast oscillator off");
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the standby and slow mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smc_pkg::*;
  typedef struct packed {
    logic [7:0]  adr;
    logic [7:0]  wdat;
    logic [31:0] exp;
  } smc_row_t;
  logic                  clk_i;
  logic                  rst_i;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [7:0]            wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  reset_pin_n_i;
  logic                  interrupt_master_enable_i;
  logic [NUM_IRQ-1:0]    interrupt_enable_flags_i;
  logic [NUM_IRQ-1:0]    interrupt_latches_i;
  logic                  time_base_irq_enable_i;
  logic                  watchdog_irq_i;
  logic [PC_W-1:0]       halt_instr_addr_i;
  logic [NUM_TB_SRC-1:0] tb_src_clk_i;
  logic                  cpu_halt_o, watchdog_halt_o, state_hold_o, periph_clk_en_o;
  logic                  tbt_clk_en_o, wake_o, irq_service_o, tbt_latch_set_o;
  logic                  hf_osc_en_o, lf_osc_en_o, sys_clk_low_o;
  logic [PC_W-1:0]       halt_pc_o;
  logic [2:0]            operating_mode_o;
  int                    n_fail = 0;
  int                    lat_cnt = 0;
  int                    n_checks = 0;
  int                    svc_cnt = 0;
  smc_row_t              rows [6];

  smc_top smc_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pin_n_i, .interrupt_master_enable_i,
    .interrupt_enable_flags_i, .interrupt_latches_i, .time_base_irq_enable_i,
    .watchdog_irq_i, .halt_instr_addr_i, .tb_src_clk_i, .cpu_halt_o, .watchdog_halt_o,
    .state_hold_o, .halt_pc_o, .periph_clk_en_o, .tbt_clk_en_o, .wake_o, .irq_service_o,
    .tbt_latch_set_o, .hf_osc_en_o, .lf_osc_en_o, .sys_clk_low_o, .operating_mode_o);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // pulses counted by nba; a one-cycle pulse can fall between task waits
  always @(posedge clk_i) begin
    if (irq_service_o === 1'b1) svc_cnt <= svc_cnt + 1;
    if (tbt_latch_set_o === 1'b1) lat_cnt <= lat_cnt + 1;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rd);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= dat;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) give_up();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] v);
    logic [31:0] d;
    wb_cycle(1'b1, adr, {24'h0, v}, d);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_cycle(1'b0, adr, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic wait_halt(input logic v);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge clk_i);
      if (cpu_halt_o === v) break;
    end
    if (cpu_halt_o !== v) give_up();
  endtask

  task automatic cpu_halt_run(input logic ime_v, input logic [7:0] ctl,
                              input logic [2:0] hmode, input logic [2:0] rmode);
    interrupt_master_enable_i <= ime_v;
    interrupt_enable_flags_i  <= 16'h0008;
    wr(ADDR_POWER_CTRL, ctl | 8'h10);
    wait_halt(1'b1);
    chk({watchdog_halt_o, state_hold_o, periph_clk_en_o, tbt_clk_en_o}, 4'hf);
    chk(halt_pc_o, halt_instr_addr_i + 16'h0002);
    interrupt_latches_i <= 16'h0010;
    @(posedge clk_i);
    chk(operating_mode_o, hmode);
    repeat (3) @(posedge clk_i);
    chk(cpu_halt_o, 1'b1);
    interrupt_latches_i <= 16'h0018;
    wait_halt(1'b0);
    chk({wake_o, irq_service_o}, {1'b1, ime_v});
    @(posedge clk_i);
    interrupt_latches_i <= 16'h0;
    chk(operating_mode_o, rmode);
    rd_chk(ADDR_POWER_CTRL, {24'h0, ctl});
  endtask

  task automatic deep_run(input logic [7:0] tbc, input logic ime_v, input logic tbie,
                          input logic exp_lat);
    int k0;
    k0 = lat_cnt;
    // peripherals are stopped, so no latch can rise while halted
    interrupt_latches_i       <= 16'h0;
    interrupt_master_enable_i <= ime_v;
    time_base_irq_enable_i    <= tbie;
    tb_src_clk_i              <= 8'hff;
    wr(ADDR_TB_CTRL, tbc);
    wr(ADDR_POWER_CTRL, 8'h84);
    wait_halt(1'b1);
    @(posedge clk_i);
    chk(lat_cnt - k0, exp_lat);
    chk({periph_clk_en_o, tbt_clk_en_o, state_hold_o, operating_mode_o},
        {3'b011, 3'h6});
    // an unselected source falling must not wake
    tb_src_clk_i <= 8'hfd;
    repeat (5) @(posedge clk_i);
    chk(cpu_halt_o, 1'b1);
    tb_src_clk_i <= 8'hf5;
    wait_halt(1'b0);
    chk({wake_o, irq_service_o}, {1'b1, ime_v & tbie & tbc[3]});
    rd_chk(ADDR_POWER_CTRL, 32'h80);
  endtask

  initial begin
    int k;
    int n;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    reset_pin_n_i = 1'b1;
    interrupt_master_enable_i = 1'b0;
    interrupt_enable_flags_i = 16'h0;
    interrupt_latches_i = 16'h0;
    time_base_irq_enable_i = 1'b0;
    watchdog_irq_i = 1'b0;
    halt_instr_addr_i = 16'h1234;
    tb_src_clk_i = 8'hff;
    rows = '{'{ADDR_STATUS, 8'hff, 32'h04}, '{ADDR_TB_CTRL, 8'hff, 32'h0f},
             '{ADDR_TB_CTRL, 8'h05, 32'h05}, '{ADDR_POWER_CTRL, 8'hcb, 32'hc0},
             '{8'h0c, 8'hff, 32'h0}, '{ADDR_POWER_CTRL, 8'h80, 32'h80}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({hf_osc_en_o, lf_osc_en_o, sys_clk_low_o, cpu_halt_o, operating_mode_o},
        {4'b1000, 3'h0});
    foreach (rows[r]) begin
      wr(rows[r].adr, rows[r].wdat);
      rd_chk(rows[r].adr, rows[r].exp);
    end
    cpu_halt_run(1'b0, 8'h80, 3'h4, 3'h0);
    cpu_halt_run(1'b1, 8'h80, 3'h4, 3'h0);
    wr(ADDR_POWER_CTRL, 8'he0);
    @(posedge clk_i);
    chk({sys_clk_low_o, lf_osc_en_o, operating_mode_o}, {2'b11, 3'h3});
    wr(ADDR_POWER_CTRL, 8'h60);
    chk({hf_osc_en_o, operating_mode_o}, {1'b0, 3'h2});
    cpu_halt_run(1'b0, 8'h60, 3'h5, 3'h2);
    wr(ADDR_POWER_CTRL, 8'he0);
    wr(ADDR_POWER_CTRL, 8'hc0);
    chk(sys_clk_low_o, 1'b1);
    n = 0;
    while (sys_clk_low_o === 1'b1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk(n > 1 && n <= SYNC_CYCLES + 2, 1'b1);
    @(posedge clk_i);
    chk(operating_mode_o, 3'h1);
    deep_run(8'h0b, 1'b1, 1'b1, 1'b1);
    deep_run(8'h03, 1'b1, 1'b1, 1'b0);
    deep_run(8'h0b, 1'b0, 1'b1, 1'b1);
    k = svc_cnt;
    watchdog_irq_i <= 1'b1;
    wr(ADDR_POWER_CTRL, 8'h90);
    repeat (4) @(posedge clk_i);
    watchdog_irq_i <= 1'b0;
    chk({cpu_halt_o, svc_cnt - k == 1}, 2'b01);
    rd_chk(ADDR_POWER_CTRL, 32'h80);
    watchdog_irq_i <= 1'b1;
    wr(ADDR_POWER_CTRL, 8'h84);
    repeat (4) @(posedge clk_i);
    watchdog_irq_i <= 1'b0;
    chk({cpu_halt_o, periph_clk_en_o, svc_cnt - k == 2}, 3'b011);
    rd_chk(ADDR_POWER_CTRL, 32'h80);
    wr(ADDR_POWER_CTRL, 8'h94);
    repeat (4) @(posedge clk_i);
    chk(cpu_halt_o, 1'b0);
    rd_chk(ADDR_POWER_CTRL, 32'h80);
    wr(ADDR_POWER_CTRL, 8'he0);
    wr(ADDR_POWER_CTRL, 8'h64);
    wait_halt(1'b1);
    chk(operating_mode_o, 3'h7);
    reset_pin_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    wait_halt(1'b0);
    repeat (4) @(posedge clk_i);
    chk({sys_clk_low_o, hf_osc_en_o, periph_clk_en_o, operating_mode_o}, {3'b011, 3'h0});
    rd_chk(ADDR_POWER_CTRL, 32'h80);
    tally_and_finish();
  end
endmodule
`default_nettype wire
